// [core/counter_array.sv]
// Programmable counter array: time base, five compare/capture modules, AXI.
`timescale 1ns/10ps

// Operation
// - Counter advances on clock/6, clock/2, timer 0 overflow or pin.
// - Source code 00 div6, 01 div2, 10 timer 0 overflow, 11 external.
// - With idle stop set the counter halts during processor idle.
// - Counter runs only while run control is set.
// - Overflow sets the overflow flag; interrupt only with its enable.
// - Overflow flag is cleared only by a software write.
// - Each module has an event flag set by match or capture.
// - Modules offer capture, software timer, fast output and 8-bit PWM.
// - Module flag interrupts only with that module's interrupt enable.
// - Toggle enable inverts the module pin on each compare match.
// - Match enable sets the module flag on each compare match.
// - Fall and rise enables arm capture edges; both arm either edge.
// - Comparator works only with compare enable set.
// - Armed pin transition copies counter bytes into the capture pair.
// - Capture interrupts only when flag and interrupt enable are set.
// - Compare plus match enables give software timer mode.
// - Toggle, match and compare enables give high-speed output mode.
// - PWM mode needs PWM enable and compare enable.
// - PWM output low while low byte below duty, high otherwise.
// - Duty byte reloads from high compare byte when low byte wraps.
// - All PWM outputs share the counter frequency; duty is per module.
// - Watchdog match on module four raises internal reset, not the pin.
module counter_array
  import counter_array_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_cpu_idle,
  input wire logic i_timer0_overflow,
  input wire logic i_ext_count_input,
  input wire logic [NUM_MODULES-1:0] i_module_io_pin,
  output logic [NUM_MODULES-1:0] o_module_io_out,
  output logic [NUM_MODULES-1:0] o_module_io_oe,
  output logic o_irq,
  output logic o_internal_reset
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic [7:0] mode_r, mode_nxt;
  logic run_r, run_nxt, ovf_flag_r, ovf_flag_nxt;
  logic [NUM_MODULES-1:0] evt_flag_r, evt_flag_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0] pre_r, pre_nxt;
  logic eval_r, eval_nxt;
  module_mode_t mmode_r [NUM_MODULES];
  module_mode_t mmode_nxt [NUM_MODULES];
  logic [15:0] cap_r [NUM_MODULES];
  logic [15:0] cap_nxt [NUM_MODULES];
  logic [7:0] duty_r [NUM_MODULES];
  logic [7:0] duty_nxt [NUM_MODULES];
  logic [NUM_MODULES-1:0] out_r, out_nxt, oe_r, oe_nxt;
  logic irq_r, irq_nxt, wdrst_r, wdrst_nxt;

  logic [2:0] ext_sync_r;
  logic [2:0] pin_sync_r [NUM_MODULES];

  logic wr_fire, step, wr_mode, wr_ctrl, wr_cnt;
  logic [NUM_MODULES-1:0] wr_mmode, wr_cap, hit, cap_evt, pwm_on;
  logic [15:0] cnt_plus;
  logic src_tick, ext_rise, wrap_low;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic hits_slot(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0] base, input int idx);
    logic [7:0] slot;
    slot = base + 8'(idx * 4);
    return addr[7:0] == slot && (ADDR_W == 8 || addr >> 8 == '0);
  endfunction : hits_slot

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Third stage only serves edge detection, so the first stays clean.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], i_ext_count_input};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++) begin : g_pin
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pin_sync_r[g] <= 3'h0;
        end else begin
          pin_sync_r[g] <= {pin_sync_r[g][1:0], i_module_io_pin[g]};
        end
      end
      always_comb begin
        // Capture uses the second and third stages only.
        cap_evt[g] = (mmode_r[g].rise_capture_enable &&
                      pin_sync_r[g][1] && !pin_sync_r[g][2]) ||
                     (mmode_r[g].fall_capture_enable &&
                      !pin_sync_r[g][1] && pin_sync_r[g][2]);
        pwm_on[g] = mmode_r[g].pwm_enable &&
                    mmode_r[g].compare_enable;
        hit[g] = eval_r && mmode_r[g].compare_enable && !pwm_on[g] &&
                 cnt_r == cap_r[g];
        wr_mmode[g] = wr_fire && hits_slot(awaddr_r, OFS_MODULE_MODE, g);
        wr_cap[g] = wr_fire && hits_slot(awaddr_r, OFS_CAPTURE, g);
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  assign o_awready = !aw_got_r && !bvalid_r;
  assign o_wready = !w_got_r && !bvalid_r;
  assign o_arready = !rvalid_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rresp = rresp_r;
  assign o_rdata = rdata_r;

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wr_mode = wr_fire && hits_slot(awaddr_r, OFS_MODE, 0);
  assign wr_ctrl = wr_fire && hits_slot(awaddr_r, OFS_CONTROL, 0);
  assign wr_cnt = wr_fire && hits_slot(awaddr_r, OFS_COUNTER, 0);

  always_comb begin
    logic mapped;
    mapped = 1'b0;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (i_awvalid && o_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = i_wdata;
      wstrb_nxt = i_wstrb;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wr_mode || wr_ctrl || wr_cnt || |wr_mmode || |wr_cap) ?
                  AXI_OKAY : AXI_SLVERR;
    end else if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      rdata_nxt = 32'h0000_0000;
      if (hits_slot(i_araddr, OFS_MODE, 0)) begin
        mapped = 1'b1;
        rdata_nxt[7:0] = mode_r;
      end
      if (hits_slot(i_araddr, OFS_CONTROL, 0)) begin
        mapped = 1'b1;
        rdata_nxt[BIT_OVERFLOW_FLAG] = ovf_flag_r;
        rdata_nxt[BIT_RUN_CONTROL] = run_r;
        rdata_nxt[NUM_MODULES-1:0] = evt_flag_r;
      end
      if (hits_slot(i_araddr, OFS_COUNTER, 0)) begin
        mapped = 1'b1;
        rdata_nxt[15:0] = cnt_r;
      end
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (hits_slot(i_araddr, OFS_MODULE_MODE, i)) begin
          mapped = 1'b1;
          rdata_nxt[7:0] = mmode_r[i];
        end
        if (hits_slot(i_araddr, OFS_CAPTURE, i)) begin
          mapped = 1'b1;
          rdata_nxt[15:0] = cap_r[i];
        end
      end
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= AXI_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  assign ext_rise = ext_sync_r[1] && !ext_sync_r[2];
  assign cnt_plus = cnt_r + 16'h0001;
  assign wrap_low = step && cnt_r[7:0] == 8'hFF;

  always_comb begin
    case (count_source_t'(mode_r[BIT_SOURCE_HI:BIT_SOURCE_LO]))
      SRC_DIV6: src_tick = pre_r == 3'(DIV6_LAST);
      SRC_DIV2: src_tick = pre_r[0];
      SRC_TIMER0: src_tick = i_timer0_overflow;
      SRC_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
    // Halted counting also freezes the divider so a restart resumes its phase.
    step = run_r && src_tick &&
           !(mode_r[BIT_IDLE_STOP] && i_cpu_idle);
    pre_nxt = pre_r;
    if (run_r && !(mode_r[BIT_IDLE_STOP] && i_cpu_idle)) begin
      pre_nxt = (pre_r == 3'(DIV6_LAST)) ? RST_PRESCALE : pre_r + 3'h1;
    end
    cnt_nxt = cnt_r;
    eval_nxt = 1'b0;
    if (wr_cnt) begin
      cnt_nxt = merge16(cnt_r, wdata_r, wstrb_r);
      eval_nxt = 1'b1;
    end else if (step) begin
      cnt_nxt = cnt_plus;
      eval_nxt = 1'b1;
    end
    mode_nxt = mode_r;
    run_nxt = run_r;
    if (wr_mode && wstrb_r[0]) begin
      mode_nxt = wdata_r[7:0] & 8'hC7;
    end
    if (wr_ctrl && wstrb_r[0]) begin
      run_nxt = wdata_r[BIT_RUN_CONTROL];
    end
    // Writing zero clears a flag; a same-cycle hardware set still wins.
    ovf_flag_nxt = ovf_flag_r;
    if (wr_ctrl && wstrb_r[0]) begin
      ovf_flag_nxt = ovf_flag_r && wdata_r[BIT_OVERFLOW_FLAG];
    end
    if (step && cnt_r == 16'hFFFF) begin
      ovf_flag_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Compare and capture modules
  // ----------------------------------------------------------------------
  always_comb begin
    logic [NUM_MODULES-1:0] pend;
    pend = '0;
    wdrst_nxt = 1'b0;
    // Flags live in this process only, so the module sets below win.
    evt_flag_nxt = evt_flag_r;
    if (wr_ctrl && wstrb_r[0]) begin
      evt_flag_nxt = evt_flag_r & wdata_r[NUM_MODULES-1:0];
    end
    for (int i = 0; i < NUM_MODULES; i++) begin
      mmode_nxt[i] = mmode_r[i];
      cap_nxt[i] = cap_r[i];
      duty_nxt[i] = duty_r[i];
      out_nxt[i] = out_r[i];
      if (wr_mmode[i] && wstrb_r[0]) begin
        mmode_nxt[i] = module_mode_t'(wdata_r[7:0] & 8'h7F);
      end
      if (wr_cap[i]) begin
        cap_nxt[i] = merge16(cap_r[i], wdata_r, wstrb_r);
      end
      if (cap_evt[i]) begin
        cap_nxt[i] = cnt_r;
        evt_flag_nxt[i] = 1'b1;
      end
      if (hit[i] && mmode_r[i].match_enable) begin
        evt_flag_nxt[i] = 1'b1;
      end
      if (pwm_on[i]) begin
        if (wrap_low) begin
          duty_nxt[i] = cap_r[i][15:8];
        end
        out_nxt[i] = cnt_r[7:0] >= duty_r[i];
      end else if (hit[i] && mmode_r[i].toggle_enable) begin
        out_nxt[i] = !out_r[i];
      end
      oe_nxt[i] = pwm_on[i] || (mmode_r[i].compare_enable &&
                                mmode_r[i].toggle_enable);
      pend[i] = evt_flag_r[i] && mmode_r[i].module_irq_enable;
    end
    if (hit[WATCHDOG_MODULE] && mode_r[BIT_WATCHDOG_ENABLE]) begin
      wdrst_nxt = 1'b1;
    end
    irq_nxt = |pend || (ovf_flag_r && mode_r[BIT_OVF_IRQ_ENABLE]);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= RST_MODE;
      run_r <= 1'b0;
      ovf_flag_r <= 1'b0;
      evt_flag_r <= '0;
      cnt_r <= RST_COUNTER;
      pre_r <= RST_PRESCALE;
      eval_r <= 1'b0;
      out_r <= '0;
      oe_r <= '0;
      irq_r <= 1'b0;
      wdrst_r <= 1'b0;
      for (int i = 0; i < NUM_MODULES; i++) begin
        mmode_r[i] <= RST_MODULE_MODE;
        cap_r[i] <= RST_CAPTURE;
        duty_r[i] <= RST_DUTY;
      end
    end else begin
      mode_r <= mode_nxt;
      run_r <= run_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      evt_flag_r <= evt_flag_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      eval_r <= eval_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      irq_r <= irq_nxt;
      wdrst_r <= wdrst_nxt;
      for (int i = 0; i < NUM_MODULES; i++) begin
        mmode_r[i] <= mmode_nxt[i];
        cap_r[i] <= cap_nxt[i];
        duty_r[i] <= duty_nxt[i];
      end
    end
  end

  assign o_module_io_out = out_r;
  assign o_module_io_oe = oe_r;
  assign o_irq = irq_r;
  assign o_internal_reset = wdrst_r;

endmodule : counter_array

// [pkg/counter_array_pkg.sv]
// Shared constants and types of the programmable counter array.
package counter_array_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int NUM_MODULES = 5;
  localparam int WATCHDOG_MODULE = 4;
  localparam int DIV6_LAST = 5;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_MODULE_MODE = 8'h10;
  localparam logic [7:0] OFS_CAPTURE = 8'h30;
  localparam logic [7:0] MODULE_STRIDE = 8'h04;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_IDLE_STOP = 7;
  localparam int BIT_WATCHDOG_ENABLE = 6;
  localparam int BIT_SOURCE_HI = 2;
  localparam int BIT_SOURCE_LO = 1;
  localparam int BIT_OVF_IRQ_ENABLE = 0;
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_RUN_CONTROL = 6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [2:0] RST_PRESCALE = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_DIV6 = 2'b00,
    SRC_DIV2 = 2'b01,
    SRC_TIMER0 = 2'b10,
    SRC_EXT = 2'b11
  } count_source_t;

  typedef struct packed {
    logic reserved;
    logic compare_enable;
    logic rise_capture_enable;
    logic fall_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic module_irq_enable;
  } module_mode_t;

  localparam module_mode_t RST_MODULE_MODE = '0;

endpackage : counter_array_pkg

// [bench/counter_array_properties.sv]
// Concurrent checks on the bus and event pins of the counter array.
`timescale 1ns/10ps
module counter_array_properties
  import counter_array_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic o_irq,
  input wire logic o_internal_reset
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_wr_refused;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write taken");

  property p_rd_refused;
    o_rvalid |-> !o_arready;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("read taken");

  property p_wr_answer;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no bvalid");

  property p_rd_answer;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");

  property p_wr_unmapped;
    i_awvalid && o_awready && i_awaddr > 8'h40
      |-> ##[1:8] o_bvalid && o_bresp == AXI_SLVERR;
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("bad bresp");

  property p_rd_unmapped;
    i_arvalid && o_arready && i_araddr > 8'h40
      |=> o_rvalid && o_rresp == AXI_SLVERR && o_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("bad rresp");

  // The flags and enables behind the request only fall by a write.
  property p_irq_fall;
    $fell(o_irq) |-> $past(o_bvalid) || $past(o_bvalid, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");

  property p_wd_pulse;
    o_internal_reset |=> !o_internal_reset;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("long reset");
endmodule : counter_array_properties

bind counter_array counter_array_properties #(.ADDR_W(ADDR_W)) u_props (
  .i_ref_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bresp, .o_bvalid, .i_araddr, .i_arvalid, .o_arready,
  .o_rdata, .o_rresp, .o_rvalid, .o_irq, .o_internal_reset
);

// [bench/pin_partner.sv]
// Model of the port pins: count input and capture inputs.
`timescale 1ns/10ps
module pin_partner
  import counter_array_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [NUM_MODULES-1:0] i_out,
  input wire logic [NUM_MODULES-1:0] i_oe,
  output logic [NUM_MODULES-1:0] o_pin,
  output logic o_ext
);
  logic [NUM_MODULES-1:0] drv = '0;

  // A pin that the block drives shows the block's level, never ours.
  assign o_pin = (i_oe & i_out) | (~i_oe & drv);

  initial o_ext = 1'h0;

  // Each level stands at least four clocks, slower on request.
  task automatic ext_pulses(input int n, input int slow);
    repeat (n) begin
      repeat (4 + slow) @(posedge i_ref_clk);
      o_ext <= 1'h1;
      repeat (4 + slow) @(posedge i_ref_clk);
      o_ext <= 1'h0;
    end
  endtask : ext_pulses

  task automatic set_pins(input logic [NUM_MODULES-1:0] v);
    @(posedge i_ref_clk);
    drv <= v;
  endtask : set_pins
endmodule : pin_partner

// [bench/test_programmable_counter_array.sv]
// Self-checking testbench of the programmable counter array.
`timescale 1ns/10ps
module test_programmable_counter_array import counter_array_pkg::*;;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic idle = 1'h0, t0 = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, wdr, ext;
  logic [1:0] bresp, rresp;
  logic [31:0] got, v;
  logic [31:0] rdata;
  logic [31:0] seed = 32'hE3B8E488;
  logic [4:0] pin, out, oe, o0;
  logic [7:0] mm[$];
  int miscompares = 0, tests_run = 0, wd_hits = 0, i, cnt, t;

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (wdr) wd_hits++;
  end

  counter_array dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'h1),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(1'h1), .i_cpu_idle(idle), .i_timer0_overflow(t0),
    .i_ext_count_input(ext), .i_module_io_pin(pin),
    .o_module_io_out(out), .o_module_io_oe(oe), .o_irq(irq),
    .o_internal_reset(wdr)
  );

  pin_partner u_pins (
    .i_ref_clk(clk), .i_out(out), .i_oe(oe), .o_pin(pin), .o_ext(ext)
  );

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] at(input logic [7:0] b, input int m);
    return b + 8'(4 * m);
  endfunction : at

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = AXI_OKAY);
    logic ta, tw, tb;
    int n;
    tb = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      if (tb) chk(bresp, r);
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    if (!tb) chk(0, 1);
    if (!tb) print_verdict();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] r = AXI_OKAY);
    logic ta, tb;
    int n;
    tb = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tb = rvalid;
      d = rdata;
      if (tb) chk(rresp, r);
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
    end
    if (!tb) chk(0, 1);
    if (!tb) print_verdict();
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, got);
    chk(got, e);
  endtask : rc

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      t0 <= 1'h1;
      @(posedge clk);
      t0 <= 1'h0;
    end
    wait_n(2);
  endtask : tick

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    wait_n(12);
    rst_n <= 1'h1;
    wait_n(1);
    rc(OFS_MODE, 0);
    rc(OFS_CONTROL, 0);
    rc(OFS_COUNTER, 0);
    for (i = 0; i < NUM_MODULES; i++) begin
      rc(at(OFS_MODULE_MODE, i), 0);
      rc(at(OFS_CAPTURE, i), 0);
      v = rnd();
      wr(at(OFS_CAPTURE, i), v);
      rc(at(OFS_CAPTURE, i), v & 32'hFFFF);
      wr(at(OFS_MODULE_MODE, i), v >> 16);
      rc(at(OFS_MODULE_MODE, i), (v >> 16) & 32'h7F);
      wr(at(OFS_MODULE_MODE, i), 0);
    end
    rd(8'h80, got, AXI_SLVERR);
    wr(8'h80, 32'hFFFFFFFF, AXI_SLVERR);
    // Source codes 00 and 01 use a divider that keeps its phase across halts, so allow one step.
    for (i = 0; i < 4; i++) begin
      wr(OFS_COUNTER, 0);
      wr(OFS_MODE, i << 1);
      wr(OFS_CONTROL, 32'h40);
      if (i < 2) wait_n(60);
      if (i == 2) tick(7);
      if (i == 3) u_pins.ext_pulses(7, i);
      wait_n(4);
      wr(OFS_CONTROL, 0);
      rd(OFS_COUNTER, got);
      cnt = (i == 0) ? 11 : (i == 1) ? 33 : 7;
      t = (i < 2);
      chk(32'(got + t >= cnt && got <= cnt + t), 1);
    end
    wr(OFS_COUNTER, 0);
    wr(OFS_MODE, 32'h84);
    wr(OFS_CONTROL, 32'h40);
    idle <= 1'h1;
    tick(3);
    rc(OFS_COUNTER, 0);
    wr(OFS_MODE, 32'h04);
    tick(3);
    rc(OFS_COUNTER, 3);
    wr(OFS_CONTROL, 0);
    tick(2);
    idle <= 1'h0;
    rc(OFS_COUNTER, 3);
    wr(OFS_MODE, 32'h05);
    wr(OFS_COUNTER, 32'hFFFF);
    wr(OFS_CONTROL, 32'h40);
    tick(1);
    rc(OFS_COUNTER, 0);
    rc(OFS_CONTROL, 32'hC0);
    chk(irq, 1);
    tick(2);
    rc(OFS_CONTROL, 32'hC0);
    wr(OFS_MODE, 32'h04);
    wait_n(2);
    chk(irq, 0);
    wr(OFS_CONTROL, 0);
    mm = '{8'h4D, 8'h48, 8'h08, 8'h44, 8'h4C};
    wr(OFS_COUNTER, 0);
    for (i = 0; i < NUM_MODULES; i++) begin
      wr(at(OFS_CAPTURE, i), 5);
      wr(at(OFS_MODULE_MODE, i), mm[i]);
    end
    o0 = out;
    wr(OFS_CONTROL, 32'h40);
    tick(6);
    rc(OFS_CONTROL, 32'h53);
    chk(out ^ o0, 5'h19);
    chk(oe, 5'h19);
    chk(irq, 1);
    chk(wd_hits, 0);
    wr(at(OFS_MODULE_MODE, 0), 32'h4C);
    wait_n(2);
    chk(irq, 0);
    wr(OFS_MODE, 32'h44);
    wr(OFS_COUNTER, 0);
    tick(6);
    chk(wd_hits, 1);
    wr(OFS_COUNTER, 0);
    wr(at(OFS_CAPTURE, 4), 32'h20);
    tick(6);
    chk(wd_hits, 1);
    wr(OFS_CONTROL, 0);
    wr(OFS_MODE, 32'h04);
    mm = '{8'h20, 8'h10, 8'h30, 8'h00, 8'h00};
    for (i = 0; i < NUM_MODULES; i++) wr(at(OFS_MODULE_MODE, i), mm[i]);
    wr(OFS_COUNTER, 32'h1234);
    u_pins.set_pins(5'h07);
    wait_n(6);
    wr(OFS_COUNTER, 32'h5678);
    u_pins.set_pins(5'h00);
    wait_n(6);
    rc(at(OFS_CAPTURE, 0), 32'h1234);
    rc(at(OFS_CAPTURE, 1), 32'h5678);
    rc(at(OFS_CAPTURE, 2), 32'h5678);
    rc(OFS_CONTROL, 32'h07);
    wr(at(OFS_MODULE_MODE, 0), 32'h21);
    wait_n(2);
    chk(irq, 1);
    wr(at(OFS_MODULE_MODE, 0), 32'h42);
    wr(at(OFS_MODULE_MODE, 1), 32'h42);
    wr(at(OFS_CAPTURE, 0), 32'h8000);
    wr(at(OFS_CAPTURE, 1), 32'h4000);
    wr(OFS_COUNTER, 32'h00FF);
    wr(OFS_CONTROL, 32'h40);
    tick(1);
    wr(OFS_CONTROL, 0);
    chk(out[1:0], 2'h0);
    wr(OFS_COUNTER, 32'h0150);
    wait_n(3);
    chk(out[1:0], 2'h2);
    wr(at(OFS_CAPTURE, 0), 0);
    wr(OFS_COUNTER, 32'h017F);
    wait_n(3);
    chk(out[0], 0);
    wr(OFS_COUNTER, 32'h0180);
    wait_n(3);
    chk(out[1:0], 2'h3);
    chk(oe[1:0], 2'h3);
    print_verdict();
  end
endmodule : test_programmable_counter_array
